// *** shared/ssrb_params.svh ***
`ifndef SSRB_PARAMS_SVH
`define SSRB_PARAMS_SVH

// Register byte offsets on the bus
`define SSRB_ADR_VOL        4'h0
`define SSRB_ADR_NV         4'h4
`define SSRB_ADR_CTRL       4'h8
`define SSRB_ADR_STAT       4'hc

// Status field positions
`define SSRB_BIT_RSVD       7
`define SSRB_BIT_PROGRAM_ERROR_FLAG     6
`define SSRB_BIT_ERASE_ERROR_FLAG     5
`define SSRB_CTRL_SWRST     0

// Reset values
`define SSRB_NV_DEFAULT     8'h00
`define SSRB_RSVD_DEFAULT   1'b0
`define SSRB_FLAG_DEFAULT   1'b0

// Access class per bit, two bits each, bit 7 first: ro, na, na, rw, rw, rw, na, na
`define SSRB_NV_CLASS       16'h42a0
// Volatile bits that software may write directly
`define SSRB_VOL_WR_MASK    8'h1c

// Serial clear-failure-flags opcode and its length in link clock edges
`define SSRB_CLR_OPCODE     8'h82
`define SSRB_OPCODE_BITS    4'h8

// Synchroniser idle levels: hw reset high, si low, chip select high, sck low
`define SSRB_PIN_IDLE       4'ha

`endif

// *** shared/ssrb_pkg.sv ***
`default_nettype none

package ssrb_pkg;

  // Bit access classes
  typedef enum logic [1:0] {
    SSRB_ACC_NA  = 2'h0,
    SSRB_ACC_RO  = 2'h1,
    SSRB_ACC_RW  = 2'h2,
    SSRB_ACC_OTP = 2'h3
  } ssrb_acc_t;

  // Reset sequencer, one-hot
  typedef enum logic [2:0] {
    SSRB_ST_RUN  = 3'b001,
    SSRB_ST_HOLD = 3'b010,
    SSRB_ST_LOAD = 3'b100
  } ssrb_rst_state_t;

endpackage

`default_nettype wire

// *** hdl/ssrb_sync.sv ***
`timescale 1ns/1ps
`default_nettype none

module ssrb_sync #(
  parameter int         WIDTH     = 4,
  parameter logic [3:0] IDLE_VAL  = 4'h0
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;

  // Two flops per pin; the first stage feeds only the second
  for (genvar b = 0; b < WIDTH; b++) begin : g_bit
    always_ff @(posedge clk) begin
      if (srst) begin
        meta_r[b]   <= IDLE_VAL[b];
        sync_out[b] <= IDLE_VAL[b];
      end else begin
        meta_r[b]   <= async_in[b];
        sync_out[b] <= meta_r[b];
      end
    end
  end

endmodule

`default_nettype wire

// *** hdl/ssrb_nv_store.sv ***
`timescale 1ns/1ps
`include "ssrb_params.svh"
`default_nettype none

module ssrb_nv_store (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  output logic      [7:0] rd_data,
  output logic      [7:0] accept
);

  localparam logic [15:0] CLASSES = `SSRB_NV_CLASS;
  localparam logic [7:0]  NV_DEF  = `SSRB_NV_DEFAULT;

  // Stand-in for the flash cells; srst models first power-on only
  logic nv_cell_r  [0:7];
  logic otp_used_r [0:7];

  for (genvar b = 0; b < 8; b++) begin : g_bit
    localparam ssrb_pkg::ssrb_acc_t CLS = ssrb_pkg::ssrb_acc_t'(CLASSES[2*b +: 2]);

    // Only rw bits, and otp bits not yet used, take a write
    assign accept[b] = wr_en && ((CLS == ssrb_pkg::SSRB_ACC_RW) ||
                                 ((CLS == ssrb_pkg::SSRB_ACC_OTP) && !otp_used_r[b]));
    assign rd_data[b] = nv_cell_r[b];

    // One-time bits lock after their first write
    always_ff @(posedge clk) begin
      if (srst) begin
        nv_cell_r[b]  <= NV_DEF[b];
        otp_used_r[b] <= 1'b0;
      end else if (accept[b]) begin
        nv_cell_r[b] <= wr_data[b];
        if (CLS == ssrb_pkg::SSRB_ACC_OTP) begin
          otp_used_r[b] <= 1'b1;
        end
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // The read-only bit 7 never moves
  fixed_bits_a: assert property (1 |=> (rd_data[7] == $past(rd_data[7])))
    else $error("read-only stored bit changed");

endmodule

`default_nettype wire

// *** hdl/ssrb_top.sv ***
// Summary of operation
// - Power-up, hardware or software reset copies stored bits into working bits.
// - Writing a stored bit also loads the same value into its working bit.
// - Writing a working bit leaves the stored bit unchanged.
// - Bit seven is reserved, read-only, always reads and is written as zero.
// - Bit six flags a failed last program operation; set means failure.
// - Program aimed at a protected region also sets the program error flag.
// - Bit five flags a failed last erase operation; set means failure.
// - Erase aimed at a protected sector also sets the erase error flag.
// - Error flags clear only by clear-fail command or hardware/software reset.
// - No standby while either error flag is set; standby drops one cycle after a flag sets.
// - Each bit has an access class; one-time bits program only once.
//
// Our own choices: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`include "ssrb_params.svh"
`default_nettype none

module ssrb_top (
  input  wire logic        clk,
  input  wire logic        srst,
  // Classic Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Serial link pins
  input  wire logic        sck_pin,
  input  wire logic        cs_n_pin,
  input  wire logic        si_pin,
  input  wire logic        hw_rst_n_pin,
  // Embedded operation results from the array engine
  input  wire logic        op_busy,
  input  wire logic        prog_done,
  input  wire logic        prog_fail,
  input  wire logic        prog_protected,
  input  wire logic        erase_done,
  input  wire logic        erase_fail,
  input  wire logic        erase_protected,
  // Status towards the rest of the device
  output logic             program_error_flag,
  output logic             erase_error_flag,
  output logic             standby,
  output logic             status_valid
);

  localparam logic [7:0] VOL_WR_MASK = `SSRB_VOL_WR_MASK;
  localparam logic [7:0] NV_DEF      = `SSRB_NV_DEFAULT;

  logic [3:0]                     pin_s;
  logic                           sck_s;
  logic                           cs_n_s;
  logic                           si_s;
  logic                           hw_rst_n_s;
  logic                           sck_prev_r;
  logic                           cs_n_prev_r;
  logic                           sck_rise;
  logic                           cs_rise;
  logic [7:0]                     shift_r;
  logic [3:0]                     bit_cnt_r;
  logic                           clr_cmd_r;
  ssrb_pkg::ssrb_rst_state_t      state_r;
  logic [4:2]                     vol_r;
  logic                           prog_err_r;
  logic                           erase_err_r;
  logic                           standby_r;
  logic                           valid_r;
  logic                           ack_r;
  logic [31:0]                    dat_r;
  logic                           req;
  logic                           wr_req;
  logic                           run;
  logic                           nv_wr_en;
  logic                           vol_wr_en;
  logic                           sw_rst_req;
  logic [7:0]                     nv_rd;
  logic [7:0]                     nv_accept;
  logic                           prog_set;
  logic                           erase_set;
  logic [7:0]                     vol_view;
  logic [31:0]                    rd_nxt;

  // Pins come from the host's domain
  ssrb_sync #(
    .WIDTH    (4),
    .IDLE_VAL (`SSRB_PIN_IDLE)
  ) u_sync (
    .clk      (clk),
    .srst     (srst),
    .async_in ({hw_rst_n_pin, si_pin, cs_n_pin, sck_pin}),
    .sync_out (pin_s)
  );

  assign sck_s      = pin_s[0];
  assign cs_n_s     = pin_s[1];
  assign si_s       = pin_s[2];
  assign hw_rst_n_s = pin_s[3];

  // Edge finders on the synchronised link clock and select
  always_ff @(posedge clk) begin
    if (srst) begin
      sck_prev_r  <= 1'b0;
      cs_n_prev_r <= 1'b1;
    end else begin
      sck_prev_r  <= sck_s;
      cs_n_prev_r <= cs_n_s;
    end
  end

  assign sck_rise = sck_s && !sck_prev_r;
  assign cs_rise  = cs_n_s && !cs_n_prev_r;

  // Opcode shifter; count saturates so long frames never alias to eight bits
  always_ff @(posedge clk) begin
    if (srst) begin
      shift_r   <= 8'h00;
      bit_cnt_r <= 4'h0;
    end else if (cs_n_s) begin
      bit_cnt_r <= 4'h0;
    end else if (sck_rise) begin
      shift_r   <= {shift_r[6:0], si_s};
      bit_cnt_r <= (bit_cnt_r == 4'hf) ? 4'hf : bit_cnt_r + 4'h1;
    end
  end

  // Command acts only when select rises after exactly eight bits
  always_ff @(posedge clk) begin
    if (srst) begin
      clr_cmd_r <= 1'b0;
    end else begin
      clr_cmd_r <= cs_rise && (bit_cnt_r == `SSRB_OPCODE_BITS) && (shift_r == `SSRB_CLR_OPCODE);
    end
  end

  // Bus request decode; one request per ack
  assign req        = wb_cyc_i && wb_stb_i && !ack_r;
  assign wr_req     = req && wb_we_i && wb_sel_i[0];
  assign run        = (state_r == ssrb_pkg::SSRB_ST_RUN);
  assign nv_wr_en   = wr_req && run && (wb_adr_i == `SSRB_ADR_NV);
  assign vol_wr_en  = wr_req && run && (wb_adr_i == `SSRB_ADR_VOL);
  assign sw_rst_req = wr_req && (wb_adr_i == `SSRB_ADR_CTRL) && wb_dat_i[`SSRB_CTRL_SWRST];

  ssrb_nv_store u_nv (
    .clk     (clk),
    .srst    (srst),
    .wr_en   (nv_wr_en),
    .wr_data (wb_dat_i[7:0]),
    .rd_data (nv_rd),
    .accept  (nv_accept)
  );

  // Reset sequencer: hold while the pin is low, then one reload cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      state_r <= ssrb_pkg::SSRB_ST_LOAD;
    end else begin
      unique case (state_r)
        ssrb_pkg::SSRB_ST_RUN: begin
          if (!hw_rst_n_s) begin
            state_r <= ssrb_pkg::SSRB_ST_HOLD;
          end else if (sw_rst_req) begin
            state_r <= ssrb_pkg::SSRB_ST_LOAD;
          end
        end
        ssrb_pkg::SSRB_ST_HOLD: begin
          if (hw_rst_n_s) begin
            state_r <= ssrb_pkg::SSRB_ST_LOAD;
          end
        end
        ssrb_pkg::SSRB_ST_LOAD: begin
          state_r <= hw_rst_n_s ? ssrb_pkg::SSRB_ST_RUN : ssrb_pkg::SSRB_ST_HOLD;
        end
        default: begin
          state_r <= ssrb_pkg::SSRB_ST_LOAD;
        end
      endcase
    end
  end

  // Working copy of the stored field bits
  always_ff @(posedge clk) begin
    if (srst) begin
      vol_r <= NV_DEF[4:2];
    end else if (state_r == ssrb_pkg::SSRB_ST_LOAD) begin
      vol_r <= nv_rd[4:2];
    end else if (nv_wr_en) begin
      vol_r <= (vol_r & ~nv_accept[4:2]) | (wb_dat_i[4:2] & nv_accept[4:2]);
    end else if (vol_wr_en) begin
      vol_r <= (vol_r & ~VOL_WR_MASK[4:2]) | (wb_dat_i[4:2] & VOL_WR_MASK[4:2]);
    end
  end

  // Failure causes; a protected target counts as failure
  assign prog_set  = (prog_done && prog_fail) || prog_protected;
  assign erase_set = (erase_done && erase_fail) || erase_protected;

  // Sticky flags: reset clears, a new failure beats the clear command
  always_ff @(posedge clk) begin
    if (srst || !run) begin
      prog_err_r  <= `SSRB_FLAG_DEFAULT;
      erase_err_r <= `SSRB_FLAG_DEFAULT;
    end else begin
      if (prog_set) begin
        prog_err_r <= 1'b1;
      end else if (clr_cmd_r) begin
        prog_err_r <= 1'b0;
      end
      if (erase_set) begin
        erase_err_r <= 1'b1;
      end else if (clr_cmd_r) begin
        erase_err_r <= 1'b0;
      end
    end
  end

  // Standby needs a deselected, idle part with clean flags
  always_ff @(posedge clk) begin
    if (srst) begin
      standby_r <= 1'b0;
      valid_r   <= 1'b0;
    end else begin
      standby_r <= run && cs_n_s && !op_busy && !prog_err_r && !erase_err_r;
      valid_r   <= run && hw_rst_n_s && !sw_rst_req;
    end
  end

  // Reserved bit is forced, never stored
  assign vol_view = {`SSRB_RSVD_DEFAULT, prog_err_r, erase_err_r, vol_r, 2'b00};

  // Read mux; unmapped offsets read zero
  always_comb begin
    rd_nxt = 32'h0000_0000;
    unique case (wb_adr_i)
      `SSRB_ADR_VOL:  rd_nxt[7:0] = vol_view;
      `SSRB_ADR_NV:   rd_nxt[7:0] = {`SSRB_RSVD_DEFAULT, nv_rd[6:0]};
      `SSRB_ADR_STAT: rd_nxt[2:0] = {standby_r, valid_r, op_busy};
      default:        rd_nxt      = 32'h0000_0000;
    endcase
  end

  // Ack one cycle after the request; every access is answered
  always_ff @(posedge clk) begin
    if (srst) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      ack_r <= req;
      if (req && !wb_we_i) begin
        dat_r <= rd_nxt;
      end
    end
  end

  assign wb_ack_o           = ack_r;
  assign wb_dat_o           = dat_r;
  assign program_error_flag = prog_err_r;
  assign erase_error_flag   = erase_err_r;
  assign standby            = standby_r;
  assign status_valid       = valid_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // Hardware reset: hold, one reload cycle, then running again
  sequence hold_release_s;
    (state_r == ssrb_pkg::SSRB_ST_HOLD) && hw_rst_n_s ##1 (state_r == ssrb_pkg::SSRB_ST_LOAD);
  endsequence

  sequence reload_done_s;
    (state_r == ssrb_pkg::SSRB_ST_LOAD) ##1 run;
  endsequence

  hw_reload_a: assert property (hold_release_s ##0 hw_rst_n_s |=> run && (vol_r == $past(nv_rd[4:2])))
    else $error("working bits not reloaded after hardware reset");

  load_copy_a: assert property ((state_r == ssrb_pkg::SSRB_ST_LOAD) |=> (vol_r == $past(nv_rd[4:2])))
    else $error("reload did not copy stored bits");

  nv_follow_a: assert property (nv_wr_en && nv_accept[3] |=> (vol_r[3] == $past(wb_dat_i[3])) &&
                                (nv_rd[3] == $past(wb_dat_i[3])))
    else $error("working bit did not follow stored write");

  vol_only_a: assert property (vol_wr_en |=> (nv_rd == $past(nv_rd)) && (vol_r == $past(wb_dat_i[4:2])))
    else $error("working write disturbed stored bits");

  rsvd_zero_a: assert property (wb_ack_o && !$past(wb_we_i) && ($past(wb_adr_i) == `SSRB_ADR_VOL)
                                |-> !wb_dat_o[`SSRB_BIT_RSVD])
    else $error("reserved bit read as one");

  prog_set_a: assert property (run && prog_set && hw_rst_n_s |=> prog_err_r)
    else $error("program failure not flagged");

  prot_prog_a: assert property (run && prog_protected && !prog_done |=> prog_err_r ##1 prog_err_r || !run)
    else $error("protected program not flagged");

  erase_set_a: assert property (run && erase_set |=> erase_err_r)
    else $error("erase failure not flagged");

  prot_erase_a: assert property (run && erase_protected |=> erase_err_r)
    else $error("protected erase not flagged");

  flag_hold_a: assert property (prog_err_r && !clr_cmd_r && run |=> prog_err_r)
    else $error("program flag dropped without clear or reset");

  clr_flag_a: assert property (clr_cmd_r && run && !prog_set && !erase_set |=> !prog_err_r && !erase_err_r)
    else $error("clear command did not clear flags");

  // One cycle only: a reload starting the cycle after the flag also satisfies the check
  no_standby_a: assert property ((prog_err_r || erase_err_r) |=> !standby_r or reload_done_s)
    else $error("standby entered with an error flag set");

  ack_pulse_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not a single pulse one cycle after request");

endmodule

`default_nettype wire

// *** verif/ssrb_host_link.sv ***
`timescale 1ns/1ps
`default_nettype none

module ssrb_host_link (
  output logic sck_pin,
  output logic cs_n_pin,
  output logic si_pin
);
  // Deselected and idle at start; link clock stands still between frames
  initial begin
    sck_pin = 1'b0;
    cs_n_pin = 1'b1;
    si_pin = 1'b0;
  end

  // One frame of n edges, MSB first, 160 ns link period, own phase
  task automatic frame(input logic [7:0] op, input int n);
    #67;
    cs_n_pin = 1'b0;
    for (int i = 0; i < n; i++) begin
      si_pin = op[3'(7 - i)];
      #80 sck_pin = 1'b1;
      #80 sck_pin = 1'b0;
    end
    #40 cs_n_pin = 1'b1;
    si_pin = ~si_pin; // Released line must not look like a held bit
  endtask
endmodule

`default_nettype wire

// *** verif/tb.sv ***
`timescale 1ns/1ps
`include "ssrb_params.svh"
`default_nettype none

module tb;
  logic        clk;
  logic        srst;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [3:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dat_i;
  logic [31:0] dat_o;
  logic        ack;
  logic        sck;
  logic        cs_n;
  logic        si;
  logic        hw_rst_n_pin;
  logic        op_busy;
  logic [5:0]  ev;
  logic        pe_o;
  logic        ee_o;
  logic        standby;
  logic        status_valid;
  int          fails;
  int          comparisons;
  logic [31:0] seed;
  logic [7:0]  nv_m;
  logic [7:0]  vf_m;
  logic [7:0]  q;
  logic        pe;
  logic        ee;

  // Event bits: prog done, fail, protected, erase done, fail, protected
  ssrb_top DUT (
    .clk(clk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_i), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .sck_pin(sck), .cs_n_pin(cs_n), .si_pin(si),
    .hw_rst_n_pin(hw_rst_n_pin), .op_busy(op_busy), .prog_done(ev[5]),
    .prog_fail(ev[4]), .prog_protected(ev[3]), .erase_done(ev[2]),
    .erase_fail(ev[1]), .erase_protected(ev[0]), .program_error_flag(pe_o),
    .erase_error_flag(ee_o), .standby(standby), .status_valid(status_valid)
  );

  ssrb_host_link host (
    .sck_pin(sck),
    .cs_n_pin(cs_n),
    .si_pin(si)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  // Working copy as the model sees it
  function automatic logic [7:0] vol_exp();
    return {1'b0, pe, ee, vf_m[4:2], 2'b00};
  endfunction

  task automatic final_report();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Classic single cycle; request held until ack is sampled
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_i <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) begin
      fails++;
      final_report();
    end
    q = dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input string nm, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk(nm, {24'h0, e}, {24'h0, q});
  endtask

  task automatic pulse(input logic [5:0] v);
    @(posedge clk);
    ev <= v;
    @(posedge clk);
    ev <= 6'h00;
    repeat (2) @(posedge clk);
  endtask

  initial begin
    srst = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 4'h0;
    sel = 4'h1;
    dat_i = 32'h0;
    hw_rst_n_pin = 1'b1;
    op_busy = 1'b0;
    ev = 6'h00;
    fails = 0;
    comparisons = 0;
    seed = 32'h1b335618;
    nv_m = 8'h00;
    vf_m = 8'h00;
    pe = 1'b0;
    ee = 1'b0;
    repeat (4) @(posedge clk);
    chk("valid in reset", 32'h0, 32'(status_valid));
    srst <= 1'b0;
    repeat (4) @(posedge clk);
    chk("valid", 32'h1, 32'(status_valid));
    rd(`SSRB_ADR_VOL, "working after reset", vol_exp());
    rd(4'h2, "unmapped", 8'h00);
    // Random stored and working writes; bit 7 of stored kept at zero
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      wb(1'b1, `SSRB_ADR_NV, seed[7:0] & 8'h7f);
      nv_m = seed[7:0] & 8'h1c;
      vf_m = nv_m;
      rd(`SSRB_ADR_VOL, "working follows stored", vol_exp());
      wb(1'b1, `SSRB_ADR_VOL, seed[15:8] & 8'h7f);
      vf_m = seed[15:8] & 8'h1c;
      rd(`SSRB_ADR_NV, "stored kept", nv_m);
      rd(`SSRB_ADR_VOL, "working written", vol_exp());
    end
    $display("test stored and working done");
    // Each failure cause, sticky, then refused and accepted clear frames
    for (int k = 0; k < 4; k++) begin
      pulse(k == 0 ? 6'h30 : k == 1 ? 6'h08 : k == 2 ? 6'h06 : 6'h01);
      pe = (k < 2);
      ee = (k >= 2);
      rd(`SSRB_ADR_VOL, "flag set", vol_exp());
      pulse(k < 2 ? 6'h20 : 6'h04);
      rd(`SSRB_ADR_VOL, "flag sticky", vol_exp());
      chk("no standby", 32'h0, 32'(standby));
      host.frame(8'h83, 8);
      host.frame(`SSRB_CLR_OPCODE, 7);
      repeat (12) @(posedge clk);
      chk("flag kept", 32'h1, 32'(pe_o | ee_o));
      host.frame(`SSRB_CLR_OPCODE, 8);
      repeat (12) @(posedge clk);
      pe = 1'b0;
      ee = 1'b0;
      chk("flags cleared", 32'h0, 32'({pe_o, ee_o}));
      chk("standby", 32'h1, 32'(standby));
      $display("test event %0d done", k);
    end
    op_busy <= 1'b1;
    rd(`SSRB_ADR_STAT, "state busy", 8'h03);
    op_busy <= 1'b0;
    // Software reset reloads working bits and clears flags
    pulse(6'h01);
    seed = xs(seed);
    wb(1'b1, `SSRB_ADR_VOL, seed[7:0] & 8'h7f);
    wb(1'b1, `SSRB_ADR_CTRL, 8'h01);
    repeat (3) @(posedge clk);
    vf_m = nv_m;
    rd(`SSRB_ADR_VOL, "sw reset reload", vol_exp());
    $display("test software reset done");
    // Hardware reset pin
    pulse(6'h08);
    wb(1'b1, `SSRB_ADR_VOL, ~nv_m & 8'h7f);
    hw_rst_n_pin <= 1'b0;
    repeat (6) @(posedge clk);
    chk("valid in hw reset", 32'h0, 32'(status_valid));
    chk("flag in hw reset", 32'h0, 32'(pe_o));
    hw_rst_n_pin <= 1'b1;
    repeat (8) @(posedge clk);
    rd(`SSRB_ADR_VOL, "hw reset reload", vol_exp());
    rd(`SSRB_ADR_NV, "stored survives", nv_m);
    $display("test hardware reset done");
    final_report();
  end
endmodule

`default_nettype wire
